//--- hw/pmdis_pkg.sv
// package: register map, implemented-bit masks and timing for the module gate bank
package pmdis_pkg;
    localparam int          AXI_AW        = 5;
    localparam int          NUM_REGS      = 6;
    localparam logic [4:0]  OFS_CTRL0     = 5'h00;
    localparam logic [4:0]  OFS_CTRL1     = 5'h04;
    localparam logic [4:0]  OFS_CTRL2     = 5'h08;
    localparam logic [4:0]  OFS_CTRL3     = 5'h0C;
    localparam logic [4:0]  OFS_CTRL4     = 5'h10;
    localparam logic [4:0]  OFS_CTRL5     = 5'h14;
    localparam logic [7:0]  MASK_CTRL0    = 8'hC7;
    localparam logic [7:0]  MASK_CTRL1    = 8'h87;
    localparam logic [7:0]  MASK_CTRL2    = 8'h67;
    localparam logic [7:0]  MASK_CTRL3    = 8'h3F;
    localparam logic [7:0]  MASK_CTRL4    = 8'hF1;
    localparam logic [7:0]  MASK_CTRL5    = 8'h1E;
    localparam logic [7:0]  RST_CTRL      = 8'h00;
    localparam logic [1:0]  RESP_OKAY     = 2'b00;
    localparam logic [1:0]  RESP_SLVERR   = 2'b10;
    localparam int          NVM_WAIT_NS   = 1000;
    localparam int          CLK_PERIOD_NS = 4;
    localparam int          NVM_WAIT_CYC  = (NVM_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // one level per gated peripheral, high means held off and in reset
    typedef struct packed {
        logic sysclk_net_off;
        logic voltage_ref_off;
        logic nonvol_mem_off;
        logic ref_clock_out_off;
        logic pin_change_irq_off;
        logic num_osc_off;
        logic timer_two_off;
        logic timer_one_off;
        logic timer_zero_off;
        logic dac_off;
        logic adc_off;
        logic comparator_two_off;
        logic comparator_one_off;
        logic zero_cross_off;
        logic pwm_ch6_off;
        logic pwm_ch5_off;
        logic pwm_ch4_off;
        logic pwm_ch3_off;
        logic capcomp_two_off;
        logic capcomp_one_off;
        logic serial_async_two_off;
        logic serial_async_one_off;
        logic sync_serial_two_off;
        logic sync_serial_one_off;
        logic waveform_gen_off;
        logic logic_cell4_off;
        logic logic_cell3_off;
        logic logic_cell2_off;
        logic logic_cell1_off;
    } pmdis_gate_t;
endpackage

//--- hw/pmdis_top.sv
// module gate bank: axi4-lite control registers driving per-peripheral disable levels
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
module pmdis_top
    import pmdis_pkg::*;
(
    input  wire logic              I_CLK,
    input  wire logic              I_RST,
    input  wire logic              I_CE,
    input  wire logic [AXI_AW-1:0] I_AWADDR,
    input  wire logic              I_AWVALID,
    output logic                   O_AWREADY,
    input  wire logic [31:0]       I_WDATA,
    input  wire logic [3:0]        I_WSTRB,
    input  wire logic              I_WVALID,
    output logic                   O_WREADY,
    output logic [1:0]             O_BRESP,
    output logic                   O_BVALID,
    input  wire logic              I_BREADY,
    input  wire logic [AXI_AW-1:0] I_ARADDR,
    input  wire logic              I_ARVALID,
    output logic                   O_ARREADY,
    output logic [31:0]            O_RDATA,
    output logic [1:0]             O_RRESP,
    output logic                   O_RVALID,
    input  wire logic              I_RREADY,
    output pmdis_gate_t            O_GATE,
    output logic                   O_NVM_READY,
    output logic                   O_PIN_ROUTE_HOLD
);
    typedef enum logic [1:0] {
        PMDIS_W_IDLE = 2'b00,
        PMDIS_W_RESP = 2'b01
    } pmdis_wst_t;

    // byte address to register slot
    function automatic logic [2:0] pmdis_index(input logic [AXI_AW-1:0] addr);
        pmdis_index = addr[AXI_AW-1:2];
    endfunction

    // implemented positions of the addressed register; nothing for a hole in the map
    function automatic logic [7:0] pmdis_mask(input logic [AXI_AW-1:0] addr);
        case (addr)
            OFS_CTRL0: pmdis_mask = MASK_CTRL0;
            OFS_CTRL1: pmdis_mask = MASK_CTRL1;
            OFS_CTRL2: pmdis_mask = MASK_CTRL2;
            OFS_CTRL3: pmdis_mask = MASK_CTRL3;
            OFS_CTRL4: pmdis_mask = MASK_CTRL4;
            OFS_CTRL5: pmdis_mask = MASK_CTRL5;
            default:   pmdis_mask = 8'h00;
        endcase
    endfunction

    // aligned word inside the bank; anything else is answered with an error
    function automatic logic pmdis_hit(input logic [AXI_AW-1:0] addr);
        pmdis_hit = addr[1:0] == 2'b00 && pmdis_index(addr) < 3'(NUM_REGS);
    endfunction

    logic [7:0]        ctrl_reg [NUM_REGS];
    logic [7:0]        ctrl_next [NUM_REGS];
    logic [AXI_AW-1:0] awaddr_reg;
    logic [AXI_AW-1:0] awaddr_next;
    logic              aw_have_reg;
    logic              aw_have_next;
    logic [7:0]        wdata_reg;
    logic [7:0]        wdata_next;
    logic              wlane_reg;
    logic              wlane_next;
    logic              w_have_reg;
    logic              w_have_next;
    pmdis_wst_t        wst_reg;
    pmdis_wst_t        wst_next;
    logic [1:0]        bresp_reg;
    logic [1:0]        bresp_next;
    logic              rvalid_reg;
    logic              rvalid_next;
    logic [31:0]       rdata_reg;
    logic [31:0]       rdata_next;
    logic [1:0]        rresp_reg;
    logic [1:0]        rresp_next;
    pmdis_gate_t       gate_reg;
    pmdis_gate_t       gate_next;
    logic              route_reg;
    logic              route_next;
    logic [9:0]        nvm_cnt_reg;
    logic [9:0]        nvm_cnt_next;
    logic              nvm_rdy_reg;
    logic              nvm_rdy_next;
    logic              do_write;
    logic              map_hit_w;
    logic              map_hit_r;

    // write address and data are captured independently, in either order
    assign O_AWREADY        = I_CE && !aw_have_reg && wst_reg == PMDIS_W_IDLE;
    assign O_WREADY         = I_CE && !w_have_reg && wst_reg == PMDIS_W_IDLE;
    assign O_BVALID         = wst_reg == PMDIS_W_RESP;
    assign O_BRESP          = bresp_reg;
    // a read is refused while its answer stands, so reads come one gap apart
    assign O_ARREADY        = I_CE && !rvalid_reg;
    assign O_RVALID         = rvalid_reg;
    assign O_RDATA          = rdata_reg;
    assign O_RRESP          = rresp_reg;
    assign O_GATE           = gate_reg;
    assign O_NVM_READY      = nvm_rdy_reg;
    assign O_PIN_ROUTE_HOLD = route_reg;

    assign map_hit_w = pmdis_hit(awaddr_reg);
    assign map_hit_r = pmdis_hit(I_ARADDR);
    assign do_write  = aw_have_reg && w_have_reg && wst_reg == PMDIS_W_IDLE;

    always_comb begin
        awaddr_next  = awaddr_reg;
        aw_have_next = aw_have_reg;
        wdata_next   = wdata_reg;
        wlane_next   = wlane_reg;
        w_have_next  = w_have_reg;
        wst_next     = wst_reg;
        bresp_next   = bresp_reg;
        for (int i = 0; i < NUM_REGS; i++) begin
            ctrl_next[i] = ctrl_reg[i];
        end
        if (O_AWREADY && I_AWVALID) begin
            awaddr_next  = I_AWADDR;
            aw_have_next = 1'b1;
        end
        if (O_WREADY && I_WVALID) begin
            // a beat without the low lane is taken and answered but changes nothing,
            // whichever of address and data arrives first
            wdata_next  = I_WDATA[7:0];
            wlane_next  = I_WSTRB[0];
            w_have_next = 1'b1;
        end
        case (wst_reg)
            PMDIS_W_IDLE: begin
                if (do_write) begin
                    if (map_hit_w) begin
                        if (wlane_reg) begin
                            // unimplemented positions are masked on write
                            ctrl_next[pmdis_index(awaddr_reg)] =
                                wdata_reg & pmdis_mask(awaddr_reg);
                        end
                        bresp_next = RESP_OKAY;
                    end else begin
                        bresp_next = RESP_SLVERR;
                    end
                    aw_have_next = 1'b0;
                    w_have_next  = 1'b0;
                    wst_next     = PMDIS_W_RESP;
                end
            end
            PMDIS_W_RESP: begin
                if (I_BREADY) begin
                    wst_next = PMDIS_W_IDLE;
                end
            end
            default: wst_next = PMDIS_W_IDLE;
        endcase
    end

    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next  = rdata_reg;
        rresp_next  = rresp_reg;
        if (rvalid_reg && I_RREADY) begin
            rvalid_next = 1'b0;
        end
        if (O_ARREADY && I_ARVALID) begin
            rvalid_next = 1'b1;
            if (map_hit_r) begin
                rdata_next = {24'h00_0000,
                    ctrl_reg[pmdis_index(I_ARADDR)] & pmdis_mask(I_ARADDR)};
                rresp_next = RESP_OKAY;
            end else begin
                rdata_next = 32'h0000_0000;
                rresp_next = RESP_SLVERR;
            end
        end
    end

    // gate levels are registered one edge after the control write lands
    always_comb begin
        gate_next.sysclk_net_off       = ctrl_reg[0][7];
        gate_next.voltage_ref_off      = ctrl_reg[0][6];
        gate_next.nonvol_mem_off       = ctrl_reg[0][2];
        gate_next.ref_clock_out_off    = ctrl_reg[0][1];
        gate_next.pin_change_irq_off   = ctrl_reg[0][0];
        gate_next.num_osc_off          = ctrl_reg[1][7];
        gate_next.timer_two_off        = ctrl_reg[1][2];
        gate_next.timer_one_off        = ctrl_reg[1][1];
        gate_next.timer_zero_off       = ctrl_reg[1][0];
        gate_next.dac_off              = ctrl_reg[2][6];
        gate_next.adc_off              = ctrl_reg[2][5];
        gate_next.comparator_two_off   = ctrl_reg[2][2];
        gate_next.comparator_one_off   = ctrl_reg[2][1];
        gate_next.zero_cross_off       = ctrl_reg[2][0];
        gate_next.pwm_ch6_off          = ctrl_reg[3][5];
        gate_next.pwm_ch5_off          = ctrl_reg[3][4];
        gate_next.pwm_ch4_off          = ctrl_reg[3][3];
        gate_next.pwm_ch3_off          = ctrl_reg[3][2];
        gate_next.capcomp_two_off      = ctrl_reg[3][1];
        gate_next.capcomp_one_off      = ctrl_reg[3][0];
        gate_next.serial_async_two_off = ctrl_reg[4][7];
        gate_next.serial_async_one_off = ctrl_reg[4][6];
        gate_next.sync_serial_two_off  = ctrl_reg[4][5];
        gate_next.sync_serial_one_off  = ctrl_reg[4][4];
        gate_next.waveform_gen_off     = ctrl_reg[4][0];
        gate_next.logic_cell4_off      = ctrl_reg[5][4];
        gate_next.logic_cell3_off      = ctrl_reg[5][3];
        gate_next.logic_cell2_off      = ctrl_reg[5][2];
        gate_next.logic_cell1_off      = ctrl_reg[5][1];
        // the peripheral reads its level as clock gate plus local reset
        // routing selections follow the owner module; any disabled owner freezes routing edits
        route_next = |gate_next;
    end

    // settle counter after memory re-enable; memory access stays blocked meanwhile
    always_comb begin
        nvm_cnt_next = nvm_cnt_reg;
        if (gate_reg.nonvol_mem_off) begin
            nvm_cnt_next = 10'(NVM_WAIT_CYC);
        end else if (nvm_cnt_reg != 10'h000) begin
            nvm_cnt_next = nvm_cnt_reg - 10'h001;
        end
        // registered so the memory side never sees a glitch on its ready level
        nvm_rdy_next = !gate_next.nonvol_mem_off && nvm_cnt_next == 10'h000;
    end

    // clock enable low freezes every group, handshakes included
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                ctrl_reg[i] <= RST_CTRL;
            end
            awaddr_reg  <= '0;
            aw_have_reg <= 1'b0;
            wdata_reg   <= 8'h00;
            wlane_reg   <= 1'b0;
            w_have_reg  <= 1'b0;
            wst_reg     <= PMDIS_W_IDLE;
            bresp_reg   <= RESP_OKAY;
        end else if (I_CE) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                ctrl_reg[i] <= ctrl_next[i];
            end
            awaddr_reg  <= awaddr_next;
            aw_have_reg <= aw_have_next;
            wdata_reg   <= wdata_next;
            wlane_reg   <= wlane_next;
            w_have_reg  <= w_have_next;
            wst_reg     <= wst_next;
            bresp_reg   <= bresp_next;
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= 32'h0000_0000;
            rresp_reg  <= RESP_OKAY;
        end else if (I_CE) begin
            rvalid_reg <= rvalid_next;
            rdata_reg  <= rdata_next;
            rresp_reg  <= rresp_next;
        end
    end

    // levels follow the bank one edge later, so the write answer leads the clock stop
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            gate_reg  <= '0;
            route_reg <= 1'b0;
        end else if (I_CE) begin
            gate_reg  <= gate_next;
            route_reg <= route_next;
        end
    end

    // memory is on after reset, so ready stands at once
    always_ff @(posedge I_CLK or posedge I_RST) begin
        if (I_RST) begin
            nvm_cnt_reg <= 10'h000;
            nvm_rdy_reg <= 1'b1;
        end else if (I_CE) begin
            nvm_cnt_reg <= nvm_cnt_next;
            nvm_rdy_reg <= nvm_rdy_next;
        end
    end
endmodule

//--- verif/pmdis_top_sva.sv
// checker: port-level properties of the module gate bank
`timescale 1ns/10ps
module pmdis_top_sva
    import pmdis_pkg::*;
(
    input wire logic        I_CLK,
    input wire logic        I_RST,
    input wire logic        O_ARREADY,
    input wire logic        O_RVALID,
    input wire logic        I_RREADY,
    input wire logic [31:0] O_RDATA,
    input wire logic        O_BVALID,
    input wire logic        I_BREADY,
    input wire logic [1:0]  O_BRESP,
    input wire pmdis_gate_t O_GATE,
    input wire logic        O_NVM_READY,
    input wire logic        O_PIN_ROUTE_HOLD
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    AST_R_HOLD: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
        else $error("read data dropped");
    AST_B_HOLD: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
        else $error("write response dropped");
    AST_RD_HI: assert property (O_RVALID |-> O_RDATA[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    AST_ROUTE: assert property (O_PIN_ROUTE_HOLD == (|O_GATE))
        else $error("route hold wrong");
    AST_NVM_OFF: assert property (O_GATE.nonvol_mem_off |-> !O_NVM_READY)
        else $error("memory ready while off");
    AST_NVM_WAIT: assert property ($fell(O_GATE.nonvol_mem_off) |-> !O_NVM_READY [*8])
        else $error("memory ready too soon");
    AST_GATE_CAUSE: assert property ($changed(O_GATE) |-> $past(O_BVALID))
        else $error("gate moved without write");
    AST_AR_BLOCK: assert property (O_RVALID |-> !O_ARREADY)
        else $error("read taken during answer");
    COV_WR: cover property (O_BVALID && I_BREADY);
    COV_RD: cover property (O_RVALID && I_RREADY);
    COV_NVM: cover property ($rose(O_NVM_READY));
endmodule

//--- verif/pmdis_periph.sv
// behavioural peripherals: each sits in reset one edge after its gate rises
`timescale 1ns/10ps
module pmdis_periph
    import pmdis_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire pmdis_gate_t i_gate,
    output logic [28:0]      o_held
);
    logic [28:0] held_reg;
    logic [28:0] held_next;
    always_comb begin
        held_next = i_gate;
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            held_reg <= 29'h000_0000;
        end else begin
            held_reg <= held_next;
        end
    end
    assign o_held = held_reg;
endmodule

//--- verif/test_pmdis_top.sv
// testbench: axi4-lite register tests for the module gate bank
`timescale 1ns/10ps
module test_pmdis_top
    import pmdis_pkg::*;
;
    logic        clk = 1'b0, rst = 1'b1, ce = 1'b1;
    logic [4:0]  awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, rd_data;
    logic [3:0]  wstrb = '0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, nvm, route;
    logic [1:0]  bresp, rresp, resp;
    pmdis_gate_t gate;
    logic [28:0] held;
    logic [7:0]  sh [6] = '{default: 8'h00};
    logic [7:0]  msk [6] = '{MASK_CTRL0, MASK_CTRL1, MASK_CTRL2, MASK_CTRL3, MASK_CTRL4, MASK_CTRL5};
    logic [4:0]  ofs [6] = '{OFS_CTRL0, OFS_CTRL1, OFS_CTRL2, OFS_CTRL3, OFS_CTRL4, OFS_CTRL5};
    int          errors = 0, checks_done = 0;
    always #2 clk = ~clk;
    pmdis_top pmdis_top_inst (.I_CLK(clk), .I_RST(rst), .I_CE(ce), .I_AWADDR(awaddr),
        .I_AWVALID(awvalid), .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb),
        .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid),
        .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
        .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
        .O_GATE(gate), .O_NVM_READY(nvm), .O_PIN_ROUTE_HOLD(route));
    pmdis_periph pmdis_periph_inst (.i_clk(clk), .i_rst(rst), .i_gate(gate), .o_held(held));
    task automatic test_done();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // address and data offered together, each dropped on its own ready
    task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [3:0] s);
        logic at = 1'b0;
        logic wt = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h00_0000, d};
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(at && wt)) begin
            @(negedge clk);
            at |= awvalid && awready;
            wt |= wvalid && wready;
            @(posedge clk);
            if (at) awvalid <= 1'b0;
            if (wt) wvalid <= 1'b0;
        end
        do @(negedge clk); while (bvalid !== 1'b1);
        resp = bresp;
        @(posedge clk);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(negedge clk); while (arready !== 1'b1);
        @(posedge clk);
        arvalid <= 1'b0;
        do @(negedge clk); while (rvalid !== 1'b1);
        rd_data = rdata;
        resp = rresp;
        @(posedge clk);
        rready <= 1'b0;
    endtask
    function automatic logic [28:0] gx();
        gx = {sh[0][7:6], sh[0][2:0], sh[1][7], sh[1][2:0], sh[2][6:5], sh[2][2:0],
              sh[3][5:0], sh[4][7:4], sh[4][0], sh[5][4:1]};
    endfunction
    task automatic cg();
        repeat (2) @(negedge clk);
        chk("gate", {3'b000, gx()}, {3'b000, gate});
        chk("held", {3'b000, gx()}, {3'b000, held});
        chk("route", {31'h0, |gx()}, {31'h0, route});
    endtask
    task automatic ck_all();
        for (int r = 0; r < 6; r++) begin
            rd(ofs[r]);
            chk("register", {24'h00_0000, sh[r]}, rd_data);
            chk("rresp", {30'h0, RESP_OKAY}, {30'h0, resp});
        end
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        ck_all();
        for (int r = 0; r < 6; r++) begin
            for (int b = 0; b < 8; b++) begin
                wr(ofs[r], 8'h01 << b, 4'h1);
                chk("bresp", {30'h0, RESP_OKAY}, {30'h0, resp});
                sh[r] = (8'h01 << b) & msk[r];
                cg();
                rd(ofs[r]);
                chk("readback", {24'h00_0000, sh[r]}, rd_data);
            end
            wr(ofs[r], 8'h00, 4'h1);
            sh[r] = 8'h00;
        end
        for (int r = 0; r < 6; r++) begin
            wr(ofs[r], 8'hFF, 4'h1);
            sh[r] = msk[r];
        end
        cg();
        chk("nvm off", 32'h0000_0000, {31'h0, nvm});
        wr(ofs[1], 8'h00, 4'h0);
        chk("strobe resp", {30'h0, RESP_OKAY}, {30'h0, resp});
        ck_all();
        wr(ofs[0], 8'h00, 4'h1);
        sh[0] = 8'h00;
        repeat (10) @(negedge clk);
        chk("nvm settle", 32'h0000_0000, {31'h0, nvm});
        repeat (NVM_WAIT_CYC - 10) @(negedge clk);
        chk("nvm last wait", 32'h0000_0000, {31'h0, nvm});
        @(negedge clk);
        chk("nvm ready", 32'h0000_0001, {31'h0, nvm});
        @(posedge clk);
        ce <= 1'b0;
        repeat (2) @(negedge clk);
        chk("ce freeze", 32'h0000_0000, {29'h0, awready, wready, arready});
        @(posedge clk);
        ce <= 1'b1;
        wr(5'h18, 8'hFF, 4'h1);
        chk("bad write", {30'h0, RESP_SLVERR}, {30'h0, resp});
        rd(5'h18);
        chk("bad read", 32'h0000_0000, rd_data);
        chk("bad rresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        sh = '{default: 8'h00};
        cg();
        ck_all();
        test_done();
    end
    initial begin
        #100_000;
        errors++;
        test_done();
    end
endmodule
bind pmdis_top pmdis_top_sva pmdis_top_sva_inst (.I_CLK(I_CLK), .I_RST(I_RST),
    .O_ARREADY(O_ARREADY), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY), .O_RDATA(O_RDATA),
    .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .O_BRESP(O_BRESP), .O_GATE(O_GATE),
    .O_NVM_READY(O_NVM_READY), .O_PIN_ROUTE_HOLD(O_PIN_ROUTE_HOLD));
